//--- dv/rcs_reset_ctrl_checker.sv
`default_nettype none
module rcs_chk (
  input wire logic pclk, // core clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb direction
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic [31:0] prdata, // apb read data
  input wire logic watchdog_reset, // watchdog pulse
  input wire logic wake_wdt, // watchdog wake
  input wire logic wake_irq, // interrupt wake
  input wire logic irq_high, // wake priority
  input wire logic high_priority_global_enable, // enable high
  input wire logic low_priority_global_enable, // enable low
  input wire logic [20:0] pc_in, // program counter
  input wire logic osc_frees_pins, // port bits freed
  input wire logic core_reset_n, // core reset
  input wire logic wake_flag_set, // wake flag
  input wire logic pc_load, // vector load
  input wire logic [20:0] pc_vector, // vector
  input wire logic tos_push, // stack push
  input wire logic [4:0] top_of_stack_upper, // tos upper
  input wire logic [7:0] top_of_stack_high, // tos high
  input wire logic [7:0] top_of_stack_low, // tos low
  input wire logic [7:0] first_port_latch_out, // latch out
  input wire logic [7:0] first_port_direction_out // direction out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // the enable matching the waking priority gates vector and push
  wire en_any = high_priority_global_enable | low_priority_global_enable;
  wire en_hit = irq_high ? high_priority_global_enable : low_priority_global_enable;
  a_apb_ready: assert property (psel && !penable |=> !pready ##1 pready) else $error("pready timing wrong");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("unmapped read not zero");
  a_wdt_core: assert property (watchdog_reset |=> !core_reset_n) else $error("core not held in reset");
  a_wake_flag: assert property (wake_irq || wake_wdt |=> wake_flag_set) else $error("wake flag missing");
  a_vec_high: assert property (wake_irq && irq_high && high_priority_global_enable |=>
    pc_load && pc_vector == 21'h000008) else $error("high vector wrong");
  a_vec_low: assert property (wake_irq && !irq_high && low_priority_global_enable |=>
    pc_load && pc_vector == 21'h000018) else $error("low vector wrong");
  a_tos_push: assert property (wake_irq && en_hit |=> tos_push &&
    {top_of_stack_upper, top_of_stack_high, top_of_stack_low} == $past(pc_in)) else $error("stack push wrong");
  a_no_vec: assert property (wake_irq && !en_any |=> !pc_load && !tos_push) else $error("vector without enable");
  a_port_hide: assert property (!osc_frees_pins [*2] |-> first_port_latch_out[7:6] == 2'h0 &&
    first_port_direction_out[7:6] == 2'h0) else $error("port bits not hidden");
  c_wdt: cover property (watchdog_reset ##1 !core_reset_n);
  c_err: cover property (pslverr);
  c_push: cover property (tos_push);
  c_wwdt: cover property (wake_wdt ##1 wake_flag_set);
endmodule // rcs_chk
`default_nettype wire

//--- dv/rcs_src_model.sv
`default_nettype none
module rcs_src_model (
  input wire logic pclk, // core clock
  output var logic master_clear_pin_n, // clear pin, active low
  output var logic brownout_reset, // supply monitor
  output var logic watchdog_reset, // watchdog expiry
  output var logic configuration_mismatch_reset, // mismatch
  output var logic reset_instr, // reset instruction
  output var logic stack_full, // stack full
  output var logic stack_underflow // stack underflow
);
  timeunit 1ns;
  timeprecision 100ps;
  // all sources idle, pin released
  initial
  begin
    master_clear_pin_n = 1'b1;
    {brownout_reset, watchdog_reset, configuration_mismatch_reset, reset_instr, stack_full, stack_underflow} = 6'h0;
  end
  // pin and monitor held six cycles, long enough for the synchroniser to see them
  task automatic fire(input int k);
    case (k)
      0: watchdog_reset <= 1'b1;
      1: configuration_mismatch_reset <= 1'b1;
      2: reset_instr <= 1'b1;
      3: stack_full <= 1'b1;
      4: stack_underflow <= 1'b1;
      5, 6: master_clear_pin_n <= 1'b0;
      default: brownout_reset <= 1'b1;
    endcase
    repeat (k > 4 ? 6 : 1) @(posedge pclk);
    master_clear_pin_n <= 1'b1;
    {brownout_reset, watchdog_reset, configuration_mismatch_reset, reset_instr, stack_full, stack_underflow} <= 6'h0;
  endtask
endmodule // rcs_src_model
`default_nettype wire

//--- dv/tb_top.sv
`include "rcs_defs.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, power_managed, wake_wdt, wake_irq, irq_high, irq;
  logic high_priority_global_enable, low_priority_global_enable, osc_frees_pins, core_reset_n;
  logic master_clear_pin_n, brownout_reset, watchdog_reset, configuration_mismatch_reset;
  logic reset_instr, stack_full, stack_underflow, wake_flag_set, wake_by_wdt, pc_load, tos_push;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [20:0] pc_in, pc_vector;
  logic [4:0] top_of_stack_upper;
  logic [7:0] top_of_stack_high, top_of_stack_low, first_port_pins, can_status_in;
  logic [7:0] first_port_latch_out, first_port_direction_out;
  int n_errors = 0;
  int total_checks = 0;
  localparam logic [11:0] BCON4 = 12'h050;
  localparam logic [11:0] BUF4 = 12'h200;
  // address, value after power-on, error expected
  logic [20:0] regs [11] = '{{`RCS_ADR_RCSR, 8'h5C, 1'b0}, {`RCS_ADR_CAUSE, 8'h00, 1'b0},
    {`RCS_ADR_ISTS, 8'h00, 1'b0}, {`RCS_ADR_IMSK, 8'h00, 1'b0}, {`RCS_ADR_PLAT, 8'h00, 1'b0},
    {`RCS_ADR_PDIR, 8'hFF, 1'b0}, {`RCS_ADR_PIN, 8'hA5, 1'b0}, {`RCS_ADR_CMIR, 8'h80, 1'b0},
    {`RCS_ADR_SMIR, 8'h3C, 1'b0}, {BCON4, 8'h00, 1'b0}, {12'h0FC, 8'h00, 1'b1}};
  // source, flags after event, cause code, status bit
  logic [22:0] srcs [8] = '{{3'd0, 8'h57, 4'h3, 8'h08}, {3'd1, 8'h4F, 4'h4, 8'h10}, {3'd2, 8'h5B, 4'h6, 8'h20},
    {3'd3, 8'h5F, 4'h7, 8'h40}, {3'd4, 8'h5F, 4'h8, 8'h80}, {3'd5, 8'h5F, 4'h1, 8'h02},
    {3'd6, 8'h5F, 4'h2, 8'h04}, {3'd7, 8'h5E, 4'h5, 8'h01}};
  logic [2:0] k;
  logic [7:0] rc, ev;
  logic [3:0] cause;
  rcs_reset_ctrl DUT (.*);
  rcs_src_model u_src (.*);
  always #2 pclk = ~pclk;
  task automatic final_report();
    if (n_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; a read compares its data with d, the idle cycle after avoids double drive
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d, input logic xe);
    int i;
    i = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++i < 20);
    if (i == 20)
    begin
      n_errors++;
      final_report();
    end
    if (!w)
      chk(prdata, {24'h0, d});
    chk(pslverr, xe);
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_core(input logic v);
    int i;
    for (i = 0; i < 30 && core_reset_n !== v; i++) @(posedge pclk);
    if (i == 30)
    begin
      n_errors++;
      final_report();
    end
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  task automatic wake(input logic w, input logic hi, input logic gh, input logic gl, input logic ld,
    input logic [20:0] v);
    pc_in <= 21'h1A5C3; wake_wdt <= w; wake_irq <= !w;
    irq_high <= hi; high_priority_global_enable <= gh; low_priority_global_enable <= gl;
    @(posedge pclk);
    wake_wdt <= 1'b0; wake_irq <= 1'b0;
    @(posedge pclk);
    chk(wake_flag_set, 1'b1);
    chk(wake_by_wdt, w);
    chk(pc_load, ld);
    if (ld)
    begin
      chk(pc_vector, v);
      chk({top_of_stack_upper, top_of_stack_high, top_of_stack_low}, 21'h1A5C3);
    end
  endtask
  initial
  begin
    {psel, penable, pwrite, power_managed, wake_wdt, wake_irq, irq_high} = 7'h0;
    {high_priority_global_enable, low_priority_global_enable, paddr, pwdata, pc_in} = '0;
    osc_frees_pins = 1'b1; first_port_pins = 8'hA5; can_status_in = 8'h3C;
    do_reset();
    foreach (regs[i]) bus(1'b0, regs[i][20:9], regs[i][8:1], regs[i][0]);
    bus(1'b1, 12'h0FC, 8'h77, 1'b1);
    bus(1'b1, `RCS_ADR_IMSK, 8'h08, 1'b0);
    bus(1'b1, BUF4, 8'hAB, 1'b0);
    bus(1'b1, BUF4 + 12'h020, 8'hFF, 1'b0);
    bus(1'b0, BUF4 + 12'h020, 8'h7F, 1'b0);
    bus(1'b1, BUF4 + 12'h02C, 8'hFF, 1'b0);
    bus(1'b0, BUF4 + 12'h02C, 8'hFB, 1'b0);
    // every reset source but power-on in turn, flags re-armed by software first
    foreach (srcs[i])
    begin
      {k, rc, cause, ev} = srcs[i];
      bus(1'b1, `RCS_ADR_RCSR, 8'hDF, 1'b0);
      bus(1'b1, `RCS_ADR_CMIR, 8'h11, 1'b0);
      bus(1'b1, BCON4, 8'h33, 1'b0);
      power_managed <= (k == 3'd6);
      u_src.fire(k);
      wait_core(1'b0);
      wait_core(1'b1);
      bus(1'b0, `RCS_ADR_CAUSE, {4'h0, cause}, 1'b0);
      bus(1'b0, `RCS_ADR_RCSR, rc, 1'b0);
      chk(irq, k == 3'd0);
      bus(1'b0, `RCS_ADR_ISTS, ev, 1'b0);
      bus(1'b0, `RCS_ADR_ISTS, 8'h00, 1'b0);
      chk(irq, 1'b0);
      bus(1'b0, `RCS_ADR_CMIR, 8'h80, 1'b0);
      bus(1'b0, BCON4, 8'h00, 1'b0);
      if (k != 3'd7)
        bus(1'b0, BUF4, 8'hAB, 1'b0);
    end
    bus(1'b1, `RCS_ADR_RCSR, 8'h40, 1'b0);
    bus(1'b0, `RCS_ADR_RCSR, 8'h5E, 1'b0);
    bus(1'b1, `RCS_ADR_CMIR, 8'h22, 1'b0);
    bus(1'b1, BCON4, 8'h44, 1'b0);
    wake(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 21'h000008);
    wake(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 21'h000018);
    wake(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 21'h0);
    wake(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 21'h0);
    wake(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 21'h0);
    bus(1'b0, `RCS_ADR_CMIR, 8'h22, 1'b0);
    bus(1'b0, BCON4, 8'h44, 1'b0);
    bus(1'b0, BUF4, 8'hAB, 1'b0);
    // oscillator takes the top port bits back
    osc_frees_pins <= 1'b0;
    bus(1'b1, `RCS_ADR_PLAT, 8'hFF, 1'b0);
    bus(1'b0, `RCS_ADR_PLAT, 8'h3F, 1'b0);
    chk(first_port_latch_out, 8'h3F);
    chk(first_port_direction_out, 8'h3F);
    bus(1'b0, `RCS_ADR_PIN, 8'h25, 1'b0);
    do_reset();
    bus(1'b0, `RCS_ADR_RCSR, 8'h5C, 1'b0);
    bus(1'b0, BCON4, 8'h00, 1'b0);
    final_report();
  end
endmodule // tb_top
bind rcs_reset_ctrl rcs_chk u_chk (.*);
`default_nettype wire

//--- hdl/rcs_buf_mem.v
`default_nettype none
// message buffer byte store, no reset so contents stay unknown after power-on
module rcs_buf_mem #(
  parameter AW = 7
) (
  input wire clk, // core clock
  input wire wr_en, // write strobe
  input wire [AW-1:0] wr_addr, // write byte index
  input wire [7:0] wr_data, // write byte
  input wire [AW-1:0] rd_addr, // read byte index
  output reg [7:0] rd_data_ff // registered read byte
);
  reg [7:0] mem [0:(1<<AW)-1];

  // one write port, registered read
  always @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_ff <= mem[rd_addr];
  end
endmodule // rcs_buf_mem
`default_nettype wire

//--- hdl/rcs_reset_ctrl.v
// Function
// - distinguish power-on, clear pin run/managed, watchdog, mismatch, brown-out, instruction, stack.
// - low five bits of reset control register are individual reset flags.
// - a flag is cleared only by its event; software sets it again.
// - software reads all flags together to identify the last reset.
// - reset control register also holds priority enable and software brown-out enable.
// - power-on or brown-out leaves buffer bytes unknown, zeroes buffer control.
// - warm resets keep buffer bytes, zero buffer control, mirrors to 1000_0000.
// - wake-up by watchdog or interrupt keeps all buffer and mirror registers.
// - unimplemented length-code bit 7 and ident-low bit 2 read zero.
// - interrupt wake-up sets a flag bit showing the wake source.
// - interrupt wake-up with global enable loads vector 0008h or 0018h.
// - such a wake-up pushes the pc to top of stack, advances pointer.
// - first port bits 6 and 7 enabled only when oscillator frees them.
`include "rcs_defs.vh"
`default_nettype none
module rcs_reset_ctrl #(
  parameter NUM_BUF = 5
) (
  input wire pclk, // core clock
  input wire presetn, // power-on reset, active low
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb direction
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output wire pready, // apb ready
  output reg [31:0] prdata, // apb read data
  output wire pslverr, // apb error, unmapped
  input wire master_clear_pin_n, // external clear pin, async
  input wire brownout_reset, // supply monitor, async
  input wire watchdog_reset, // watchdog expiry pulse
  input wire configuration_mismatch_reset, // mismatch pulse
  input wire reset_instr, // reset instruction pulse
  input wire stack_full, // stack full reset pulse
  input wire stack_underflow, // stack underflow pulse
  input wire power_managed, // core in power-managed mode
  input wire wake_wdt, // wake-up by watchdog pulse
  input wire wake_irq, // wake-up by interrupt pulse
  input wire irq_high, // waking interrupt is high priority
  input wire high_priority_global_enable, // global enable high
  input wire low_priority_global_enable, // global enable low
  input wire [20:0] pc_in, // current program counter
  input wire osc_frees_pins, // oscillator frees port bits 6,7
  input wire [7:0] first_port_pins, // port pin levels, async
  input wire [7:0] can_status_in, // live can mode status
  output reg core_reset_n, // core reset, active low
  output reg wake_flag_set, // set wake flag in interrupt regs
  output reg wake_by_wdt, // wake flag is the watchdog
  output reg pc_load, // load pc from pc_vector
  output reg [20:0] pc_vector, // interrupt vector
  output reg tos_push, // write tos and advance pointer
  output reg [4:0] top_of_stack_upper, // pushed pc bits 20:16
  output reg [7:0] top_of_stack_high, // pushed pc bits 15:8
  output reg [7:0] top_of_stack_low, // pushed pc bits 7:0
  output reg [7:0] first_port_latch_out, // port latch to pads
  output reg [7:0] first_port_direction_out, // port direction to pads
  output wire irq // level interrupt
);
  localparam AW = 7;

  wire clr_raw;
  wire bor_raw;
  reg [1:0] sync1_ff;
  reg [1:0] sync2_ff;
  reg [1:0] prev_ff;
  reg [7:0] pin1_ff;
  reg [7:0] pin2_ff;
  reg [7:0] rcsr_ff;
  reg [3:0] cause_ff;
  reg [7:0] ists_ff;
  reg [7:0] imsk_ff;
  reg [7:0] plat_ff;
  reg [7:0] pdir_ff;
  reg [7:0] cmir_ff;
  reg [7:0] smir_ff;
  reg [8*NUM_BUF-1:0] bcon_ff;
  reg acc_ff;
  reg [7:0] nxt_rcsr;
  reg [3:0] nxt_cause;
  reg [7:0] ev;
  reg [31:0] rd_mux;
  reg hit;
  wire clr_lvl;
  wire bor_lvl;
  wire clr_evt;
  wire bor_evt;
  wire warm_evt;
  wire any_src;
  wire wr_ok;
  wire rd_ok;
  wire in_mem;
  wire [11:0] moff;
  wire [AW-1:0] mem_idx;
  wire [7:0] mem_q;
  wire [7:0] mem_wd;
  wire [7:0] port_mask;
  wire gie_ok;

  assign clr_raw = ~master_clear_pin_n;
  assign bor_raw = brownout_reset; // gated only after the synchroniser, no glitch path

  // two-stage sync of the asynchronous sources, one chain per bit
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_sync
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
          prev_ff[gi] <= 1'b0;
        end
        else
        begin
          sync1_ff[gi] <= (gi == 0) ? clr_raw : bor_raw;
          sync2_ff[gi] <= sync1_ff[gi];
          prev_ff[gi] <= sync2_ff[gi];
        end
      end
    end
  endgenerate

  // port pins are pads, synchronised before any read
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin1_ff <= 8'h00;
      pin2_ff <= 8'h00;
    end
    else
    begin
      pin1_ff <= first_port_pins;
      pin2_ff <= pin1_ff;
    end
  end

  assign clr_lvl = sync2_ff[0];
  assign bor_lvl = sync2_ff[1] & rcsr_ff[`RCS_BIT_SBOR];
  assign clr_evt = clr_lvl & ~prev_ff[0];
  assign bor_evt = bor_lvl & ~prev_ff[1];
  // warm class keeps buffer bytes; brown-out is the cold class
  assign warm_evt = clr_evt | watchdog_reset | configuration_mismatch_reset |
                    reset_instr | stack_full | stack_underflow;
  // level sources hold the reset for their whole duration
  assign any_src = clr_lvl | bor_lvl | watchdog_reset | configuration_mismatch_reset |
                   reset_instr | stack_full | stack_underflow;

  // event vector, one bit per distinct source
  always @*
  begin
    ev = 8'h00;
    ev[`RCS_EV_BOR] = bor_evt;
    ev[`RCS_EV_CLR_RUN] = clr_evt & ~power_managed;
    ev[`RCS_EV_CLR_PM] = clr_evt & power_managed;
    ev[`RCS_EV_WDT] = watchdog_reset;
    ev[`RCS_EV_CM] = configuration_mismatch_reset;
    ev[`RCS_EV_INSTR] = reset_instr;
    ev[`RCS_EV_STKFUL] = stack_full;
    ev[`RCS_EV_STKUNF] = stack_underflow;
  end

  // last cause, priority when two sources coincide
  always @*
  begin
    nxt_cause = cause_ff;
    if (ev[`RCS_EV_BOR])
      nxt_cause = `RCS_CAUSE_BOR;
    else if (ev[`RCS_EV_CLR_RUN])
      nxt_cause = `RCS_CAUSE_CLR_RUN;
    else if (ev[`RCS_EV_CLR_PM])
      nxt_cause = `RCS_CAUSE_CLR_PM;
    else if (ev[`RCS_EV_WDT])
      nxt_cause = `RCS_CAUSE_WDT;
    else if (ev[`RCS_EV_CM])
      nxt_cause = `RCS_CAUSE_CM;
    else if (ev[`RCS_EV_STKFUL])
      nxt_cause = `RCS_CAUSE_STKFUL;
    else if (ev[`RCS_EV_STKUNF])
      nxt_cause = `RCS_CAUSE_STKUNF;
    else if (ev[`RCS_EV_INSTR])
      nxt_cause = `RCS_CAUSE_INSTR;
  end

  // apb: every access takes one wait state so the buffer read settles
  assign pready = psel & penable & acc_ff;
  assign wr_ok = pready & pwrite;
  assign rd_ok = pready & ~pwrite;
  assign pslverr = pready & ~hit;
  assign in_mem = paddr >= `RCS_ADR_BMEM;
  assign moff = paddr - `RCS_ADR_BMEM;
  assign mem_idx = moff[AW+1:2];

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      acc_ff <= 1'b0;
    else
      acc_ff <= psel & penable & ~acc_ff;
  end

  // reset flags: software can only set them; hardware clear beats a set in one cycle
  always @*
  begin
    nxt_rcsr = rcsr_ff;
    if (wr_ok && paddr == `RCS_ADR_RCSR)
      nxt_rcsr = {pwdata[7:5], rcsr_ff[4:0] | pwdata[4:0]};
    nxt_rcsr[5] = 1'b0;
    if (bor_evt)
    begin
      nxt_rcsr[`RCS_BIT_BOR] = 1'b0;
      nxt_rcsr[`RCS_BIT_INTERRUPT_PRIORITY_ENABLE] = 1'b0;
    end
    if (warm_evt)
      nxt_rcsr[`RCS_BIT_INTERRUPT_PRIORITY_ENABLE] = 1'b0;
    if (watchdog_reset)
      nxt_rcsr[`RCS_BIT_WDT] = 1'b0;
    if (reset_instr)
      nxt_rcsr[`RCS_BIT_INSTR] = 1'b0;
    if (configuration_mismatch_reset)
      nxt_rcsr[`RCS_BIT_CM] = 1'b0;
  end

  // software-visible registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rcsr_ff <= `RCS_RCSR_RST;
      cause_ff <= `RCS_CAUSE_POR;
      ists_ff <= 8'h00;
      imsk_ff <= 8'h00;
      plat_ff <= 8'h00;
      pdir_ff <= 8'hFF;
    end
    else
    begin
      rcsr_ff <= nxt_rcsr;
      cause_ff <= nxt_cause;
      // read clears only the bits it returned, so later events survive
      if (rd_ok && paddr == `RCS_ADR_ISTS)
        ists_ff <= (ists_ff & ~prdata[7:0]) | ev;
      else
        ists_ff <= ists_ff | ev;
      if (wr_ok && paddr == `RCS_ADR_IMSK)
        imsk_ff <= pwdata[7:0];
      if (wr_ok && paddr == `RCS_ADR_PLAT)
        plat_ff <= pwdata[7:0];
      if (wr_ok && paddr == `RCS_ADR_PDIR)
        pdir_ff <= pwdata[7:0];
    end
  end

  assign irq = |(ists_ff & imsk_ff);

  // mirrors: loaded on any reset class, kept on wake-up
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmir_ff <= `RCS_MIRROR_RST;
      smir_ff <= `RCS_MIRROR_RST;
    end
    else if (any_src || bor_evt || warm_evt)
    begin
      cmir_ff <= `RCS_MIRROR_RST;
      smir_ff <= `RCS_MIRROR_RST;
    end
    else
    begin
      if (wr_ok && paddr == `RCS_ADR_CMIR)
        cmir_ff <= pwdata[7:0];
      smir_ff <= can_status_in;
    end
  end

  // buffer control registers, one per buffer
  generate
    for (gi = 0; gi < NUM_BUF; gi = gi + 1)
    begin : g_bcon
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          bcon_ff[8*gi+7:8*gi] <= `RCS_BCON_RST;
        else if (any_src || bor_evt || warm_evt)
          bcon_ff[8*gi+7:8*gi] <= `RCS_BCON_RST;
        else if (wr_ok && paddr == `RCS_ADR_BCON + 4 * gi)
          bcon_ff[8*gi+7:8*gi] <= pwdata[7:0];
      end
    end
  endgenerate

  // bytes land with unimplemented bits forced low
  assign mem_wd = (mem_idx[3:0] == `RCS_SLOT_DLC) ? (pwdata[7:0] & `RCS_DLC_MASK) :
                  (mem_idx[3:0] == `RCS_SLOT_SIDL) ? (pwdata[7:0] & `RCS_SIDL_MASK) :
                  pwdata[7:0];

  // buffer bytes are never touched by any reset class
  rcs_buf_mem #(
    .AW(AW)
  ) u_mem (
    .clk(pclk),
    .wr_en(wr_ok & in_mem & (moff < 64 * NUM_BUF)),
    .wr_addr(mem_idx),
    .wr_data(mem_wd),
    .rd_addr(mem_idx),
    .rd_data_ff(mem_q)
  );

  assign port_mask = osc_frees_pins ? 8'hFF : `RCS_PORT_HI_MASK;

  // port view: freed bits follow the oscillator mode
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first_port_latch_out <= 8'h00;
      first_port_direction_out <= 8'h00;
    end
    else
    begin
      first_port_latch_out <= plat_ff & port_mask;
      first_port_direction_out <= pdir_ff & port_mask;
    end
  end

  // read decode, unmapped register reads give zero and an error; past the buffer window the error comes with buffer data
  always @*
  begin
    rd_mux = 32'h00000000;
    hit = 1'b1;
    if (in_mem)
    begin
      hit = moff < 64 * NUM_BUF;
      if (mem_idx[3:0] == `RCS_SLOT_DLC)
        rd_mux[7:0] = mem_q & `RCS_DLC_MASK;
      else if (mem_idx[3:0] == `RCS_SLOT_SIDL)
        rd_mux[7:0] = mem_q & `RCS_SIDL_MASK;
      else
        rd_mux[7:0] = mem_q;
    end
    else if (paddr >= `RCS_ADR_BCON && paddr < `RCS_ADR_BCON + 4 * NUM_BUF)
      rd_mux[7:0] = bcon_ff[8*((paddr-`RCS_ADR_BCON)>>2) +: 8];
    else
    begin
      case (paddr)
        `RCS_ADR_RCSR: rd_mux[7:0] = rcsr_ff;
        `RCS_ADR_CAUSE: rd_mux[3:0] = cause_ff;
        `RCS_ADR_ISTS: rd_mux[7:0] = ists_ff;
        `RCS_ADR_IMSK: rd_mux[7:0] = imsk_ff;
        `RCS_ADR_PLAT: rd_mux[7:0] = plat_ff & port_mask;
        `RCS_ADR_PDIR: rd_mux[7:0] = pdir_ff & port_mask;
        `RCS_ADR_PIN: rd_mux[7:0] = pin2_ff & port_mask;
        `RCS_ADR_CMIR: rd_mux[7:0] = cmir_ff;
        `RCS_ADR_SMIR: rd_mux[7:0] = smir_ff;
        default: hit = 1'b0;
      endcase
    end
  end

  // read data captured in the first access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && penable && !acc_ff && !pwrite)
      prdata <= rd_mux;
  end

  // core reset held while any source stays asserted
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      core_reset_n <= 1'b0;
    else
      core_reset_n <= ~any_src;
  end

  assign gie_ok = irq_high ? high_priority_global_enable : low_priority_global_enable;

  // interrupt wake-up: flag, vector and stack push in one cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_flag_set <= 1'b0;
      wake_by_wdt <= 1'b0;
      pc_load <= 1'b0;
      pc_vector <= 21'h000000;
      tos_push <= 1'b0;
      top_of_stack_upper <= 5'h00;
      top_of_stack_high <= 8'h00;
      top_of_stack_low <= 8'h00;
    end
    else
    begin
      wake_flag_set <= wake_irq | wake_wdt;
      wake_by_wdt <= wake_wdt & ~wake_irq;
      pc_load <= wake_irq & gie_ok;
      tos_push <= wake_irq & gie_ok;
      if (wake_irq && gie_ok)
      begin
        pc_vector <= irq_high ? `RCS_VEC_HI : `RCS_VEC_LO;
        top_of_stack_upper <= pc_in[20:16];
        top_of_stack_high <= pc_in[15:8];
        top_of_stack_low <= pc_in[7:0];
      end
    end
  end
endmodule // rcs_reset_ctrl
`default_nettype wire

//--- shared/rcs_defs.vh
`ifndef RCS_DEFS_VH
`define RCS_DEFS_VH
// register byte offsets on the apb bus
`define RCS_ADR_RCSR 12'h000
`define RCS_ADR_CAUSE 12'h004
`define RCS_ADR_ISTS 12'h008
`define RCS_ADR_IMSK 12'h00C
`define RCS_ADR_PLAT 12'h010
`define RCS_ADR_PDIR 12'h014
`define RCS_ADR_PIN 12'h018
`define RCS_ADR_CMIR 12'h01C
`define RCS_ADR_SMIR 12'h020
`define RCS_ADR_BCON 12'h040
`define RCS_ADR_BMEM 12'h100
// reset control and status fields
`define RCS_BIT_BOR 0
`define RCS_BIT_POR 1
`define RCS_BIT_INSTR 2
`define RCS_BIT_WDT 3
`define RCS_BIT_CM 4
`define RCS_BIT_SBOR 6
`define RCS_BIT_INTERRUPT_PRIORITY_ENABLE 7
`define RCS_RCSR_RST 8'h5C
// interrupt status layout, one bit per source
`define RCS_EV_BOR 0
`define RCS_EV_CLR_RUN 1
`define RCS_EV_CLR_PM 2
`define RCS_EV_WDT 3
`define RCS_EV_CM 4
`define RCS_EV_INSTR 5
`define RCS_EV_STKFUL 6
`define RCS_EV_STKUNF 7
// last-cause codes
`define RCS_CAUSE_POR 4'h0
`define RCS_CAUSE_CLR_RUN 4'h1
`define RCS_CAUSE_CLR_PM 4'h2
`define RCS_CAUSE_WDT 4'h3
`define RCS_CAUSE_CM 4'h4
`define RCS_CAUSE_BOR 4'h5
`define RCS_CAUSE_INSTR 4'h6
`define RCS_CAUSE_STKFUL 4'h7
`define RCS_CAUSE_STKUNF 4'h8
// per-reset values and unimplemented-bit masks
`define RCS_MIRROR_RST 8'h80
`define RCS_BCON_RST 8'h00
`define RCS_SLOT_DLC 4'h8
`define RCS_SLOT_SIDL 4'hB
`define RCS_DLC_MASK 8'h7F
`define RCS_SIDL_MASK 8'hFB
`define RCS_PORT_HI_MASK 8'h3F
`define RCS_VEC_HI 21'h000008
`define RCS_VEC_LO 21'h000018
`endif
